// *** include/cmpctl_pkg.sv ***
package cmpctl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONV_CTRL_B = 8'h03;
   localparam logic [7:0] IDX_CMP_CTRL = 8'h08;
   localparam logic [7:0] IDX_DIN_DIS = 8'h09;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h0A;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h0B;
   localparam int ADDR_W = 8;
   // converter_control_b fields
   localparam int MUX_SEL_EN_BIT = 6;
   // comparator_control_status fields
   localparam int CMP_DIS_BIT = 7;
   localparam int BG_SEL_BIT = 6;
   localparam int RESULT_BIT = 5;
   localparam int FLAG_BIT = 4;
   localparam int IRQ_EN_BIT = 3;
   localparam int MODE_HI_BIT = 1;
   localparam int MODE_LO_BIT = 0;
   // digital_input_disable fields
   localparam int NEG_BUF_DIS_BIT = 5;
   localparam int POS_BUF_DIS_BIT = 4;
   // sticky status / mask fields
   localparam int STAT_FLAG_SET_BIT = 0;
   localparam int STAT_TOGGLE_BIT = 1;
   localparam int STAT_W = 2;
   // event mode encodings
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_FALL = 2'h2;
   localparam logic [1:0] MODE_RISE = 2'h3;
   // reset values
   localparam logic [7:0] CONV_CTRL_B_RST = 8'h00;
   localparam logic [7:0] CMP_CTRL_RST = 8'h00;
   localparam logic [7:0] DIN_DIS_RST = 8'h00;
   localparam logic [1:0] STAT_RST = 2'h0;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // synchroniser depth in cycles
   localparam int SYNC_STAGES = 2;
endpackage : cmpctl_pkg

// *** hdl/cmpctl_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmpctl_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic [cmpctl_pkg::SYNC_STAGES-1:0] stage_r;

   // first stage feeds only the next stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage_r <= '0;
      end else begin
         stage_r <= {stage_r[cmpctl_pkg::SYNC_STAGES-2:0], din};
      end
   end

   assign dout = stage_r[cmpctl_pkg::SYNC_STAGES-1];
endmodule : cmpctl_sync
`default_nettype wire

// *** hdl/cmpctl_top.sv ***
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cmpctl_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter and processor status
   input wire logic converter_enable,
   input wire logic [1:0] channel_select,
   input wire logic global_irq_enable,
   input wire logic vector_ack,
   // analog comparator core
   input wire logic comparator_raw,
   output logic pos_sel_bandgap,
   output logic neg_sel_channel,
   output logic [1:0] neg_channel,
   output logic comparator_power_off,
   // input pins
   input wire logic positive_pin_din,
   input wire logic negative_pin_din,
   output logic positive_pin_read,
   output logic negative_pin_read,
   output logic positive_buffer_disable,
   output logic negative_buffer_disable,
   // interrupts
   output logic comparator_irq_req,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   logic mux_select_enable_r;
   logic comparator_disable_r;
   logic bandgap_select_r;
   logic comparator_irq_enable_r;
   logic [1:0] event_mode_r;
   logic comparator_event_flag_r;
   logic [1:0] buf_dis_r;
   logic [cmpctl_pkg::STAT_W-1:0] stat_r;
   logic [cmpctl_pkg::STAT_W-1:0] mask_r;
   logic sync_q;
   logic prev_r;
   logic rise;
   logic fall;
   logic hit;
   logic aw_full_r;
   logic w_full_r;
   logic [cmpctl_pkg::ADDR_W-1:0] aw_idx_r;
   logic [7:0] wbyte_r;
   logic wstrb0_r;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic bvalid_nxt;
   logic rvalid_nxt;
   logic aw_full_nxt;
   logic w_full_nxt;
   logic wr_cmp;
   logic wr_flag_clr;

   function automatic logic [cmpctl_pkg::ADDR_W-1:0] word_idx(input logic [31:0] a);
      word_idx = a[cmpctl_pkg::ADDR_W+1:2];
   endfunction : word_idx

   function automatic logic mapped(input logic [cmpctl_pkg::ADDR_W-1:0] i);
      mapped = (i == cmpctl_pkg::IDX_CONV_CTRL_B) || (i == cmpctl_pkg::IDX_CMP_CTRL) ||
               (i == cmpctl_pkg::IDX_DIN_DIS) || (i == cmpctl_pkg::IDX_IRQ_STAT) ||
               (i == cmpctl_pkg::IDX_IRQ_MASK);
   endfunction : mapped

   // event decode from mode and edges
   function automatic logic mode_hit(input logic [1:0] m, input logic r, input logic f);
      unique case (m)
         cmpctl_pkg::MODE_TOGGLE: mode_hit = r | f;
         cmpctl_pkg::MODE_RESERVED: mode_hit = 1'b0;
         cmpctl_pkg::MODE_FALL: mode_hit = f;
         cmpctl_pkg::MODE_RISE: mode_hit = r;
      endcase
   endfunction : mode_hit

   ////////////////////////////////////////////////////////////////////
   // write channel
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign aw_full_nxt = do_write ? 1'b0 : (aw_full_r | aw_take);
   assign w_full_nxt = do_write ? 1'b0 : (w_full_r | w_take);
   assign bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);
   assign wr_cmp = do_write & wstrb0_r & (aw_idx_r == cmpctl_pkg::IDX_CMP_CTRL);
   assign wr_flag_clr = wr_cmp & wbyte_r[cmpctl_pkg::FLAG_BIT];

   always_ff @(posedge mclk) begin
      if (rst) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_idx_r <= '0;
         wbyte_r <= 8'h00;
         wstrb0_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cmpctl_pkg::RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         if (aw_take) begin
            aw_idx_r <= word_idx(s_axi_awaddr);
         end
         if (w_take) begin
            wbyte_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
         s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
         s_axi_bvalid <= bvalid_nxt;
         if (do_write) begin
            s_axi_bresp <= mapped(aw_idx_r) ? cmpctl_pkg::RESP_OKAY : cmpctl_pkg::RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read channel
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= cmpctl_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_nxt;
         s_axi_rvalid <= rvalid_nxt;
         if (ar_take) begin
            s_axi_rresp <= mapped(word_idx(s_axi_araddr)) ? cmpctl_pkg::RESP_OKAY : cmpctl_pkg::RESP_SLVERR;
            s_axi_rdata <= 32'h00000000;
            unique case (word_idx(s_axi_araddr))
               cmpctl_pkg::IDX_CONV_CTRL_B: s_axi_rdata[cmpctl_pkg::MUX_SEL_EN_BIT] <= mux_select_enable_r;
               cmpctl_pkg::IDX_CMP_CTRL: begin
                  s_axi_rdata[cmpctl_pkg::CMP_DIS_BIT] <= comparator_disable_r;
                  s_axi_rdata[cmpctl_pkg::BG_SEL_BIT] <= bandgap_select_r;
                  s_axi_rdata[cmpctl_pkg::RESULT_BIT] <= sync_q;
                  s_axi_rdata[cmpctl_pkg::FLAG_BIT] <= comparator_event_flag_r;
                  s_axi_rdata[cmpctl_pkg::IRQ_EN_BIT] <= comparator_irq_enable_r;
                  s_axi_rdata[cmpctl_pkg::MODE_HI_BIT:cmpctl_pkg::MODE_LO_BIT] <= event_mode_r;
               end
               cmpctl_pkg::IDX_DIN_DIS: begin
                  s_axi_rdata[cmpctl_pkg::NEG_BUF_DIS_BIT:cmpctl_pkg::POS_BUF_DIS_BIT] <= buf_dis_r;
               end
               cmpctl_pkg::IDX_IRQ_STAT: s_axi_rdata[cmpctl_pkg::STAT_W-1:0] <= stat_r;
               cmpctl_pkg::IDX_IRQ_MASK: s_axi_rdata[cmpctl_pkg::STAT_W-1:0] <= mask_r;
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         mux_select_enable_r <= cmpctl_pkg::CONV_CTRL_B_RST[cmpctl_pkg::MUX_SEL_EN_BIT];
         comparator_disable_r <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::CMP_DIS_BIT];
         bandgap_select_r <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::BG_SEL_BIT];
         comparator_irq_enable_r <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::IRQ_EN_BIT];
         event_mode_r <= cmpctl_pkg::CMP_CTRL_RST[cmpctl_pkg::MODE_HI_BIT:cmpctl_pkg::MODE_LO_BIT];
         buf_dis_r <= cmpctl_pkg::DIN_DIS_RST[cmpctl_pkg::NEG_BUF_DIS_BIT:cmpctl_pkg::POS_BUF_DIS_BIT];
         mask_r <= cmpctl_pkg::STAT_RST;
      end else if (do_write && wstrb0_r) begin
         unique case (aw_idx_r)
            cmpctl_pkg::IDX_CONV_CTRL_B: mux_select_enable_r <= wbyte_r[cmpctl_pkg::MUX_SEL_EN_BIT];
            cmpctl_pkg::IDX_CMP_CTRL: begin
               comparator_disable_r <= wbyte_r[cmpctl_pkg::CMP_DIS_BIT];
               bandgap_select_r <= wbyte_r[cmpctl_pkg::BG_SEL_BIT];
               comparator_irq_enable_r <= wbyte_r[cmpctl_pkg::IRQ_EN_BIT];
               event_mode_r <= wbyte_r[cmpctl_pkg::MODE_HI_BIT:cmpctl_pkg::MODE_LO_BIT];
            end
            cmpctl_pkg::IDX_DIN_DIS: begin
               buf_dis_r <= wbyte_r[cmpctl_pkg::NEG_BUF_DIS_BIT:cmpctl_pkg::POS_BUF_DIS_BIT];
            end
            cmpctl_pkg::IDX_IRQ_MASK: mask_r <= wbyte_r[cmpctl_pkg::STAT_W-1:0];
            default: mask_r <= mask_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // input selection and power towards the analog core
   always_ff @(posedge mclk) begin
      if (rst) begin
         pos_sel_bandgap <= 1'b0;
         neg_sel_channel <= 1'b0;
         neg_channel <= 2'h0;
         comparator_power_off <= 1'b0;
      end else begin
         pos_sel_bandgap <= bandgap_select_r;
         neg_sel_channel <= mux_select_enable_r & ~converter_enable;
         neg_channel <= channel_select;
         comparator_power_off <= comparator_disable_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin buffer gating
   always_ff @(posedge mclk) begin
      if (rst) begin
         positive_buffer_disable <= 1'b0;
         negative_buffer_disable <= 1'b0;
         positive_pin_read <= 1'b0;
         negative_pin_read <= 1'b0;
      end else begin
         positive_buffer_disable <= buf_dis_r[0];
         negative_buffer_disable <= buf_dis_r[1];
         positive_pin_read <= positive_pin_din & ~buf_dis_r[0];
         negative_pin_read <= negative_pin_din & ~buf_dis_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result synchroniser and edge detect
   cmpctl_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .din(comparator_raw),
      .dout(sync_q)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_r;
   assign fall = ~sync_q & prev_r;
   assign hit = mode_hit(event_mode_r, rise, fall);

   ////////////////////////////////////////////////////////////////////
   // event flag, request and sticky status
   always_ff @(posedge mclk) begin
      if (rst) begin
         comparator_event_flag_r <= 1'b0;
      end else begin
         comparator_event_flag_r <= hit | (comparator_event_flag_r & ~vector_ack & ~wr_flag_clr);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_r <= cmpctl_pkg::STAT_RST;
      end else begin
         stat_r[cmpctl_pkg::STAT_FLAG_SET_BIT] <= hit | (stat_r[cmpctl_pkg::STAT_FLAG_SET_BIT] &
            ~(do_write & wstrb0_r & (aw_idx_r == cmpctl_pkg::IDX_IRQ_STAT) & wbyte_r[cmpctl_pkg::STAT_FLAG_SET_BIT]));
         stat_r[cmpctl_pkg::STAT_TOGGLE_BIT] <= (rise | fall) | (stat_r[cmpctl_pkg::STAT_TOGGLE_BIT] &
            ~(do_write & wstrb0_r & (aw_idx_r == cmpctl_pkg::IDX_IRQ_STAT) & wbyte_r[cmpctl_pkg::STAT_TOGGLE_BIT]));
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         comparator_irq_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         comparator_irq_req <= comparator_event_flag_r & comparator_irq_enable_r & global_irq_enable;
         irq <= |(stat_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_neg_input_sel: assert property (@(posedge mclk) disable iff (rst)
      ##1 (neg_sel_channel == ($past(mux_select_enable_r) & ~$past(converter_enable))))
      else $error("negative input selection wrong");
   a_neg_channel: assert property (@(posedge mclk) disable iff (rst)
      neg_sel_channel |-> (neg_channel == $past(channel_select)))
      else $error("channel selection wrong");
   a_pos_input_sel: assert property (@(posedge mclk) disable iff (rst)
      ##1 (pos_sel_bandgap == $past(bandgap_select_r)))
      else $error("positive input selection wrong");
   a_power_off: assert property (@(posedge mclk) disable iff (rst)
      wr_cmp |-> ##2 (comparator_power_off == $past(wbyte_r[cmpctl_pkg::CMP_DIS_BIT], 2)))
      else $error("power control not following write");
   a_sync_latency: assert property (@(posedge mclk) disable iff (rst)
      ##2 (sync_q == $past(comparator_raw, 2)))
      else $error("synchronised result latency wrong");
   a_rise_sets: assert property (@(posedge mclk) disable iff (rst)
      (event_mode_r == cmpctl_pkg::MODE_RISE && sync_q && !prev_r) |=> comparator_event_flag_r)
      else $error("rising edge did not set flag");
   a_flag_cause: assert property (@(posedge mclk) disable iff (rst)
      $rose(comparator_event_flag_r) |-> $past(event_mode_r) != cmpctl_pkg::MODE_RESERVED)
      else $error("flag set in reserved mode");
   a_irq_request: assert property (@(posedge mclk) disable iff (rst)
      comparator_irq_req |-> $past(comparator_event_flag_r & comparator_irq_enable_r & global_irq_enable))
      else $error("request without all enables");
   a_vector_clear: assert property (@(posedge mclk) disable iff (rst)
      (vector_ack && !hit) |=> !comparator_event_flag_r)
      else $error("vector did not clear flag");
   a_w1c_clear: assert property (@(posedge mclk) disable iff (rst)
      (wr_cmp && !wbyte_r[cmpctl_pkg::FLAG_BIT] && !vector_ack && comparator_event_flag_r) |=> comparator_event_flag_r)
      else $error("writing zero changed flag");
   a_buffer_gate: assert property (@(posedge mclk) disable iff (rst)
      positive_buffer_disable |-> !positive_pin_read)
      else $error("disabled pin read not zero");
endmodule : cmpctl_top
`default_nettype wire

// *** verif/cmpctl_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmpctl_core_model #(
   parameter logic [11:0] BANDGAP_MV = 12'h4B0,
   parameter logic [11:0] PIN_THRESH_MV = 12'h180
) (
   // analog levels set by the bench
   input wire logic [11:0] pos_pin_mv,
   input wire logic [11:0] neg_pin_mv,
   input wire logic [11:0] ch0_mv,
   input wire logic [11:0] ch1_mv,
   input wire logic [11:0] ch2_mv,
   input wire logic [11:0] ch3_mv,
   // selection from the block
   input wire logic pos_sel_bandgap,
   input wire logic neg_sel_channel,
   input wire logic [1:0] neg_channel,
   input wire logic comparator_power_off,
   // comparator and pin buffers
   output logic comparator_raw,
   output logic positive_pin_din,
   output logic negative_pin_din
);
   logic [11:0] plus_mv;
   logic [11:0] minus_mv;
   always_comb begin
      plus_mv = pos_sel_bandgap ? BANDGAP_MV : pos_pin_mv;
      case (neg_channel)
         2'h0: minus_mv = ch0_mv;
         2'h1: minus_mv = ch1_mv;
         2'h2: minus_mv = ch2_mv;
         default: minus_mv = ch3_mv;
      endcase
      if (!neg_sel_channel) begin
         minus_mv = neg_pin_mv;
      end
   end
   // a powered-down comparator gives a low output
   assign comparator_raw = !comparator_power_off && (plus_mv > minus_mv);
   assign positive_pin_din = pos_pin_mv > PIN_THRESH_MV;
   assign negative_pin_din = neg_pin_mv > PIN_THRESH_MV;
endmodule : cmpctl_core_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, channel_select, neg_channel;
   logic converter_enable, global_irq_enable, vector_ack, raw, bg, nsel, poff;
   logic pdin, ndin, pread, nread, pbd, nbd, irq_req, irq;
   logic [11:0] pos_mv, neg_mv;
   logic [11:0] ch_mv [4];
   int errors, n_tests;
   ////////////////////////////////////////////////////////////////
   cmpctl_top dut_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .converter_enable(converter_enable), .channel_select(channel_select),
      .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .comparator_raw(raw),
      .pos_sel_bandgap(bg), .neg_sel_channel(nsel), .neg_channel(neg_channel), .comparator_power_off(poff),
      .positive_pin_din(pdin), .negative_pin_din(ndin), .positive_pin_read(pread),
      .negative_pin_read(nread), .positive_buffer_disable(pbd), .negative_buffer_disable(nbd),
      .comparator_irq_req(irq_req), .irq(irq));
   cmpctl_core_model model_u (.pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .ch0_mv(ch_mv[0]),
      .ch1_mv(ch_mv[1]), .ch2_mv(ch_mv[2]), .ch3_mv(ch_mv[3]), .pos_sel_bandgap(bg),
      .neg_sel_channel(nsel), .neg_channel(neg_channel), .comparator_power_off(poff),
      .comparator_raw(raw), .positive_pin_din(pdin), .negative_pin_din(ndin));
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic end_of_test();
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
      int n;
      awaddr <= addr;
      wdata <= data;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 100) begin
         errors++;
         end_of_test();
      end
      check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
      int n;
      araddr <= addr;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 100) begin
         errors++;
         end_of_test();
      end
      check("rdata", exp, rdata);
      check("rresp", {30'h0, exp_resp}, {30'h0, rresp});
      @(posedge mclk);
   endtask : rd
   task automatic settle();
      repeat (5) @(posedge mclk);
   endtask : settle
   ////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, vector_ack, global_irq_enable, converter_enable} = 8'h00;
      awaddr = 32'h0;
      araddr = 32'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      channel_select = 2'h0;
      pos_mv = 12'h200;
      neg_mv = 12'h300;
      ch_mv = '{12'h300, 12'h300, 12'h300, 12'h300};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      // reset values and unmapped places
      rd(32'h0000000C, 32'h0, 2'h0);
      rd(32'h00000020, 32'h0, 2'h0);
      rd(32'h00000024, 32'h0, 2'h0);
      rd(32'h00000028, 32'h0, 2'h0);
      rd(32'h00000040, 32'h0, 2'h2);
      wr(32'h00000040, 32'h000000FF, 2'h2);
      // pin buffers
      check("pin_reads", 32'h3, {30'h0, pread, nread});
      wr(32'h00000024, 32'h000000FF, 2'h0);
      rd(32'h00000024, 32'h00000030, 2'h0);
      settle();
      check("buf_dis", 32'hC, {28'h0, pbd, nbd, pread, nread});
      wr(32'h00000024, 32'h00000000, 2'h0);
      // converter multiplexer as negative input, power reduction already clear
      wr(32'h0000000C, 32'h000000FF, 2'h0);
      rd(32'h0000000C, 32'h00000040, 2'h0);
      // toggle mode from reset: the first result edge sets the flag, which stays set
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 4; j++) begin
            ch_mv[j] <= (j == k) ? 12'h100 : 12'h300;
         end
         channel_select <= 2'(k);
         settle();
         rd(32'h00000020, 32'h00000030, 2'h0);
      end
      converter_enable <= 1'b1;
      settle();
      rd(32'h00000020, 32'h00000010, 2'h0);
      converter_enable <= 1'b0;
      wr(32'h0000000C, 32'h00000000, 2'h0);
      settle();
      rd(32'h00000020, 32'h00000010, 2'h0);
      // bandgap on the positive input, reserved bit written high
      wr(32'h00000020, 32'h00000044, 2'h0);
      settle();
      rd(32'h00000020, 32'h00000070, 2'h0);
      wr(32'h00000020, 32'h00000000, 2'h0);
      settle();
      // event modes, irq enable kept low while the mode changes
      for (int m = 0; m < 4; m++) begin
         wr(32'h00000020, 32'(m), 2'h0);
         wr(32'h00000020, 32'h10 | 32'(m), 2'h0);
         pos_mv <= 12'h400;
         settle();
         rd(32'h00000020, 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 32'h0), 2'h0);
         wr(32'h00000020, 32'(m), 2'h0);
         rd(32'h00000020, 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 32'h0), 2'h0);
         wr(32'h00000020, 32'h10 | 32'(m), 2'h0);
         rd(32'h00000020, 32'h20 | 32'(m), 2'h0);
         pos_mv <= 12'h200;
         settle();
         rd(32'h00000020, 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 32'h0), 2'h0);
         wr(32'h00000020, 32'h10 | 32'(m), 2'h0);
      end
      // interrupt request gating and vector clear
      wr(32'h00000020, 32'h00000013, 2'h0);
      wr(32'h00000020, 32'h0000000B, 2'h0);
      pos_mv <= 12'h400;
      settle();
      check("irq_req_gie0", 32'h0, {31'h0, irq_req});
      global_irq_enable <= 1'b1;
      repeat (3) @(posedge mclk);
      check("irq_req", 32'h1, {31'h0, irq_req});
      vector_ack <= 1'b1;
      @(posedge mclk);
      vector_ack <= 1'b0;
      repeat (3) @(posedge mclk);
      check("irq_req_ack", 32'h0, {31'h0, irq_req});
      rd(32'h00000020, 32'h0000002B, 2'h0);
      // sticky status and mask
      rd(32'h00000028, 32'h00000003, 2'h0);
      check("irq_masked", 32'h0, {31'h0, irq});
      wr(32'h0000002C, 32'h00000001, 2'h0);
      repeat (2) @(posedge mclk);
      check("irq_unmasked", 32'h1, {31'h0, irq});
      wr(32'h00000028, 32'h00000001, 2'h0);
      repeat (2) @(posedge mclk);
      check("irq_cleared", 32'h0, {31'h0, irq});
      rd(32'h00000028, 32'h00000002, 2'h0);
      rd(32'h0000002C, 32'h00000001, 2'h0);
      // power off, irq enable dropped first
      wr(32'h00000020, 32'h00000003, 2'h0);
      wr(32'h00000020, 32'h00000083, 2'h0);
      settle();
      check("power_off", 32'h1, {31'h0, poff});
      rd(32'h00000020, 32'h00000083, 2'h0);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
